// *** rtl/ranging_pkg.sv ***
// constants, register map and types of the ranging code sequencer
// assumes a single 10 MHz clock and a 32-bit AXI4-Lite register bus
`default_nettype none
package ranging_pkg;
  // ********************************
  // widths
  // ********************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;
  localparam int PHASE_W = 24;
  localparam int OUT_W = 16;
  localparam int ORDER_W = 5;
  localparam int ORDER_MAX = 20;
  localparam int ACK_W = 8;
  localparam logic [ORDER_W-1:0] LAST_MAX = 5'h14;
  // ********************************
  // register byte addresses
  // ********************************
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 8'h00;
  localparam logic [ADDR_W-1:0] TONE_ADDR = 8'h04;
  localparam logic [ADDR_W-1:0] DWELL_ADDR = 8'h08;
  localparam logic [ADDR_W-1:0] MODIDX_ADDR = 8'h0C;
  localparam logic [ADDR_W-1:0] RREQ_ADDR = 8'h10;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h14;
  localparam logic [ADDR_W-1:0] RDATA_ADDR = 8'h18;
  localparam logic [ADDR_W-1:0] DREQ_ADDR = 8'h1C;
  localparam logic [ADDR_W-1:0] DDATA_ADDR = 8'h20;
  // ********************************
  // field positions and reset values
  // ********************************
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_REP_BIT = 1;
  localparam int CTRL_MODE_LSB = 2;
  localparam int CTRL_LAST_LSB = 4;
  localparam int ST_IDX_LSB = 4;
  localparam int ST_RVAL_BIT = 9;
  localparam int ST_DVAL_BIT = 10;
  localparam int ST_RACK_LSB = 16;
  localparam int ST_DACK_LSB = 24;
  localparam int MOD_MEAS_LSB = 16;
  localparam logic [DATA_W-1:0] CTRL_RST = 32'h0000_0140;
  localparam logic [DATA_W-1:0] TONE_RST = 32'h0019_999A;
  localparam logic [DATA_W-1:0] DWELL_RST = 32'h0000_03E8;
  // phase in units of a full turn / 2^16: 45 deg and 22.5 deg
  localparam logic [OUT_W-1:0] MOD_ACQ_RST = 16'h2000;
  localparam logic [OUT_W-1:0] MOD_MEAS_RST = 16'h1000;
  localparam logic [1:0] QUAD_0 = 2'h0;
  localparam logic [1:0] QUAD_90 = 2'h1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ********************************
  // types
  // ********************************
  typedef enum logic [1:0] {
    MODE_DEEP = 2'h0,
    MODE_COH = 2'h1,
    MODE_NONCOH = 2'h2
  } mode_type;
  typedef enum logic [3:0] {
    ST_OFF = 4'h1,
    ST_TONE = 4'h2,
    ST_CODES = 4'h4,
    ST_FINAL = 4'h8
  } state_type;
endpackage
`default_nettype wire

// *** rtl/code_divider.sv ***
// divide-by-two chain and code former for the ambiguity codes
// assumes toneTick pulses once per tone period at the 90 degree point
`default_nettype none
module code_divider import ranging_pkg::*; #(
  parameter int STAGES = ORDER_MAX
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // control
  input wire logic toneTick,
  input wire logic clear,
  input wire logic [ORDER_W-1:0] order,
  // code out
  output logic codeBit,
  output logic codeEpoch
);
  logic [STAGES-1:0] chain_reg;
  logic [STAGES-1:0] chain_next;
  logic [STAGES-1:0] mask;

  // ********************************
  // square waves
  // ********************************
  // stage i toggles every 2^(i-1) tone periods: wave i at ft/2^i
  assign chain_next = chain_reg + {{(STAGES-1){1'b0}}, 1'b1};

  genvar i;
  generate
    for (i = 0; i < STAGES; i++) begin : gMask
      // waves 1..n take part in code n
      assign mask[i] = (i < int'(order));
    end
  endgenerate

  // ********************************
  // code
  // ********************************
  // xor of the chain equals repeating code n-1 then its inverse
  always_ff @(posedge clk) begin
    if (!nrst || clear) begin
      chain_reg <= '0;
      codeBit <= 1'b0;
      codeEpoch <= 1'b0;
    end else begin
      codeEpoch <= 1'b0;
      if (toneTick) begin
        chain_reg <= chain_next;
        // change only on the 90 degree tick
        codeBit <= ^(chain_next & mask);
        // code period is 2^n tone periods
        codeEpoch <= ((chain_next & mask) == '0);
      end
    end
  end
endmodule
`default_nettype wire

// *** rtl/axil_slave.sv ***
// AXI4-Lite slave front end turning bus transfers into register strobes
// assumes the register file answers address validity combinationally
`default_nettype none
module axil_slave import ranging_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // write channels
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [STRB_W-1:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // read channels
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  // register side
  output logic wrEn,
  output logic [ADDR_W-1:0] wrAddr,
  output logic [DATA_W-1:0] wrData,
  output logic [STRB_W-1:0] wrStrb,
  input wire logic wrOk,
  output logic rdEn,
  output logic [ADDR_W-1:0] rdAddr,
  input wire logic [DATA_W-1:0] rdData,
  input wire logic rdOk
);
  logic awHave_reg;
  logic wHave_reg;

  // ********************************
  // write path
  // ********************************
  // address and data may arrive in either order; one write at a time
  assign awready = !awHave_reg && !bvalid;
  assign wready = !wHave_reg && !bvalid;
  assign wrEn = awHave_reg && wHave_reg && !bvalid;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      awHave_reg <= 1'b0;
      wHave_reg <= 1'b0;
      wrAddr <= '0;
      wrData <= '0;
      wrStrb <= '0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awHave_reg <= 1'b1;
        wrAddr <= awaddr;
      end
      if (wvalid && wready) begin
        wHave_reg <= 1'b1;
        wrData <= wdata;
        wrStrb <= wstrb;
      end
      if (wrEn) begin
        awHave_reg <= 1'b0;
        wHave_reg <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wrOk ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // ********************************
  // read path
  // ********************************
  assign arready = !rvalid;
  assign rdEn = arvalid && arready;
  assign rdAddr = araddr;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else if (rdEn) begin
      rvalid <= 1'b1;
      rdata <= rdOk ? rdData : '0;
      rresp <= rdOk ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** rtl/ranging_code_sequencer.sv ***
// ranging tone and code sequencer with ranging and Doppler capture
// assumes one 10 MHz clock, AXI4-Lite software access, and
// single-cycle replica and Doppler count pulses synchronous to clk
//
// Implementation choices: the register addresses and the AXI4-Lite slave port.
`default_nettype none
// Notes on behaviour
// - acquisition runs tone alone, then each code in turn, then the final code
// - optional deep-space restart of the code series after the final code
// - output is the tone phase-shifted by plus or minus index per code bit
// - code transitions fall exactly on the tone's 90 degree point
// - code n is the exclusive-or of square waves one to n
// - square wave i runs at tone frequency over two to the i
// - square waves come from a divide-by-two chain stepped by the tone
// - code n equals code n-1 followed by its inverse
// - each code stays for a configured number of tone periods
// - ranging requests are accepted and each accepted one is acknowledged
// - deep space, coherent and non-coherent near Earth modes are selectable
// - ranging result is time from transmitted epoch to received replica epoch
// - ranging results are held locally until software reads them out
// - Doppler requests are accepted and each one acknowledged
// - Doppler counts are integrated, stored, readable and passed to ranging
// - code period is two to the n tone periods, n from 0 to 20
// - index 45 degrees while resolving, 22.5 when measuring; phase shown
module ranging_code_sequencer import ranging_pkg::*; #(
  parameter int ACC_W = PHASE_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // AXI4-Lite write
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [STRB_W-1:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  // measurement inputs
  input wire logic replicaEpoch,
  input wire logic dopplerTick,
  // modulator side
  output logic [OUT_W-1:0] basebandPhase,
  output logic codeBit,
  output logic measurePhase,
  output logic [OUT_W-1:0] modIndex,
  output logic coherentRef,
  output logic [DATA_W-1:0] dopplerForRanging
);
  // ********************************
  // declarations
  // ********************************
  logic wrEn;
  logic [ADDR_W-1:0] wrAddr;
  logic [DATA_W-1:0] wrData;
  logic [STRB_W-1:0] wrStrb;
  logic wrOk;
  logic rdEn;
  logic [ADDR_W-1:0] rdAddr;
  logic [DATA_W-1:0] rdData;
  logic rdOk;
  logic [DATA_W-1:0] ctrl_reg;
  logic [DATA_W-1:0] tone_reg;
  logic [DATA_W-1:0] dwell_reg;
  logic [DATA_W-1:0] modidx_reg;
  logic [ACC_W-1:0] phase_reg;
  logic [1:0] quadPrev_reg;
  logic toneTick;
  state_type state_reg;
  logic [ORDER_W-1:0] codeIndex_reg;
  logic [DATA_W-1:0] dwellCnt_reg;
  logic dwellDone;
  logic enable;
  logic repeatOn;
  mode_type mode;
  logic [ORDER_W-1:0] lastCode;
  logic rangeReq;
  logic dopReq;
  logic codeActive;
  logic [ORDER_W-1:0] codeOrder;
  logic codeEpoch;
  logic [OUT_W-1:0] offset;
  logic rangeRun_reg;
  logic [DATA_W-1:0] rangeTimer_reg;
  logic [DATA_W-1:0] rangeData_reg;
  logic rangeValid_reg;
  logic rangeSet;
  logic rangeClr;
  logic [ACK_W-1:0] rangeAck_reg;
  logic [DATA_W-1:0] dopRemain_reg;
  logic [DATA_W-1:0] dopCount_reg;
  logic [DATA_W-1:0] dopData_reg;
  logic dopValid_reg;
  logic dopSet;
  logic dopClr;
  logic [ACK_W-1:0] dopAck_reg;

  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
      input logic [DATA_W-1:0] nw, input logic [STRB_W-1:0] strb);
    logic [DATA_W-1:0] r;
    r = old;
    for (int b = 0; b < STRB_W; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  // ********************************
  // bus slave
  // ********************************
  axil_slave uBus (
    .clk(clk),
    .nrst(nrst),
    .awvalid(awvalid),
    .awready(awready),
    .awaddr(awaddr),
    .wvalid(wvalid),
    .wready(wready),
    .wdata(wdata),
    .wstrb(wstrb),
    .bvalid(bvalid),
    .bready(bready),
    .bresp(bresp),
    .arvalid(arvalid),
    .arready(arready),
    .araddr(araddr),
    .rvalid(rvalid),
    .rready(rready),
    .rdata(rdata),
    .rresp(rresp),
    .wrEn(wrEn),
    .wrAddr(wrAddr),
    .wrData(wrData),
    .wrStrb(wrStrb),
    .wrOk(wrOk),
    .rdEn(rdEn),
    .rdAddr(rdAddr),
    .rdData(rdData),
    .rdOk(rdOk)
  );

  // ********************************
  // registers
  // ********************************
  assign wrOk = (wrAddr == CTRL_ADDR) || (wrAddr == TONE_ADDR) ||
      (wrAddr == DWELL_ADDR) || (wrAddr == MODIDX_ADDR) ||
      (wrAddr == RREQ_ADDR) || (wrAddr == DREQ_ADDR);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrl_reg <= CTRL_RST;
      tone_reg <= TONE_RST;
      dwell_reg <= DWELL_RST;
      modidx_reg <= {MOD_MEAS_RST, MOD_ACQ_RST};
    end else if (wrEn) begin
      case (wrAddr)
        CTRL_ADDR: ctrl_reg <= merge(ctrl_reg, wrData, wrStrb);
        TONE_ADDR: tone_reg <= merge(tone_reg, wrData, wrStrb);
        DWELL_ADDR: dwell_reg <= merge(dwell_reg, wrData, wrStrb);
        MODIDX_ADDR: modidx_reg <= merge(modidx_reg, wrData, wrStrb);
        default: ;
      endcase
    end
  end

  assign enable = ctrl_reg[CTRL_EN_BIT];
  assign mode = mode_type'(ctrl_reg[CTRL_MODE_LSB +: 2]);
  // restart of the series only makes sense far out; near Earth holds
  assign repeatOn = ctrl_reg[CTRL_REP_BIT] && (mode == MODE_DEEP);
  assign coherentRef = (mode == MODE_COH);
  // orders above the chain length are clamped
  assign lastCode = (ctrl_reg[CTRL_LAST_LSB +: ORDER_W] > LAST_MAX) ?
      LAST_MAX : ctrl_reg[CTRL_LAST_LSB +: ORDER_W];
  // ranging requests are only taken while ranging is enabled; Doppler requests at any time
  assign rangeReq = wrEn && (wrAddr == RREQ_ADDR) && enable;
  assign dopReq = wrEn && (wrAddr == DREQ_ADDR);

  always_comb begin
    rdOk = 1'b1;
    rdData = '0;
    case (rdAddr)
      CTRL_ADDR: rdData = ctrl_reg;
      TONE_ADDR: rdData = tone_reg;
      DWELL_ADDR: rdData = dwell_reg;
      MODIDX_ADDR: rdData = modidx_reg;
      RREQ_ADDR: rdData = '0;
      DREQ_ADDR: rdData = '0;
      STATUS_ADDR: begin
        rdData[3:0] = state_reg;
        rdData[ST_IDX_LSB +: ORDER_W] = codeIndex_reg;
        rdData[ST_RVAL_BIT] = rangeValid_reg;
        rdData[ST_DVAL_BIT] = dopValid_reg;
        rdData[ST_RACK_LSB +: ACK_W] = rangeAck_reg;
        rdData[ST_DACK_LSB +: ACK_W] = dopAck_reg;
      end
      RDATA_ADDR: rdData = rangeData_reg;
      DDATA_ADDR: rdData = dopData_reg;
      default: rdOk = 1'b0;
    endcase
  end

  assign rangeClr = rdEn && (rdAddr == RDATA_ADDR);
  assign dopClr = rdEn && (rdAddr == DDATA_ADDR);

  // ********************************
  // tone
  // ********************************
  // tone frequency is software's choice; the step must keep it in range
  always_ff @(posedge clk) begin
    if (!nrst) begin
      phase_reg <= '0;
      quadPrev_reg <= QUAD_0;
    end else begin
      phase_reg <= phase_reg + tone_reg[ACC_W-1:0];
      quadPrev_reg <= phase_reg[ACC_W-1 -: 2];
    end
  end

  // one pulse per tone period as the phase enters its second quadrant
  assign toneTick = (quadPrev_reg == QUAD_0) &&
      (phase_reg[ACC_W-1 -: 2] == QUAD_90);

  // ********************************
  // sequencer
  // ********************************
  assign dwellDone = ({1'b0, dwellCnt_reg} + 33'h1) >= {1'b0, dwell_reg};

  always_ff @(posedge clk) begin
    if (!nrst || !enable) begin
      state_reg <= ST_OFF;
      codeIndex_reg <= '0;
      dwellCnt_reg <= '0;
    end else if (rangeReq) begin
      state_reg <= ST_TONE;
      codeIndex_reg <= '0;
      dwellCnt_reg <= '0;
    end else if (toneTick) begin
      case (state_reg)
        ST_OFF: ;
        ST_TONE: begin
          // tone alone first, held for the dwell
          if (dwellDone) begin
            dwellCnt_reg <= '0;
            if (lastCode == '0) begin
              state_reg <= ST_FINAL;
            end else begin
              state_reg <= ST_CODES;
              codeIndex_reg <= {{(ORDER_W-1){1'b0}}, 1'b1};
            end
          end else begin
            dwellCnt_reg <= dwellCnt_reg + 32'h1;
          end
        end
        ST_CODES: begin
          // codes in increasing order, one dwell each
          if (dwellDone) begin
            dwellCnt_reg <= '0;
            if (codeIndex_reg >= lastCode) begin
              state_reg <= ST_FINAL;
            end else begin
              codeIndex_reg <= codeIndex_reg + 5'h1;
            end
          end else begin
            dwellCnt_reg <= dwellCnt_reg + 32'h1;
          end
        end
        ST_FINAL: begin
          // final code held, or series restarted when enabled
          if (repeatOn) begin
            if (dwellDone) begin
              dwellCnt_reg <= '0;
              state_reg <= (lastCode == '0) ? ST_FINAL : ST_CODES;
              codeIndex_reg <= (lastCode == '0) ? '0 : 5'h1;
            end else begin
              dwellCnt_reg <= dwellCnt_reg + 32'h1;
            end
          end
        end
        default: state_reg <= ST_OFF;
      endcase
    end
  end

  assign codeActive = (state_reg == ST_CODES) || (state_reg == ST_FINAL);
  assign codeOrder = codeActive ? codeIndex_reg : '0;

  code_divider #(
    .STAGES(ORDER_MAX)
  ) uCode (
    .clk(clk),
    .nrst(nrst),
    .toneTick(toneTick),
    .clear(rangeReq || !enable),
    .order(codeOrder),
    .codeBit(codeBit),
    .codeEpoch(codeEpoch)
  );

  // ********************************
  // baseband output
  // ********************************
  // measurement phase starts once the final code is on the air
  assign measurePhase = (state_reg == ST_FINAL);
  assign modIndex = measurePhase ? modidx_reg[MOD_MEAS_LSB +: OUT_W] :
      modidx_reg[OUT_W-1:0];
  // code bit shifts the tone phase by plus or minus the index
  assign offset = !codeActive ? '0 : (codeBit ? modIndex : (~modIndex + 16'h1));

  always_ff @(posedge clk) begin
    if (!nrst) begin
      basebandPhase <= '0;
    end else begin
      basebandPhase <= phase_reg[ACC_W-1 -: OUT_W] + offset;
    end
  end

  // ********************************
  // ranging measurement
  // ********************************
  // timer runs from a transmitted code epoch to the replica epoch
  assign rangeSet = rangeRun_reg && replicaEpoch;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rangeRun_reg <= 1'b0;
      rangeTimer_reg <= '0;
      rangeData_reg <= '0;
    end else if (rangeSet) begin
      rangeRun_reg <= 1'b0;
      rangeData_reg <= rangeTimer_reg;
    end else if (codeEpoch && measurePhase && !rangeRun_reg) begin
      rangeRun_reg <= 1'b1;
      rangeTimer_reg <= 32'h1;
    end else if (rangeRun_reg) begin
      rangeTimer_reg <= rangeTimer_reg + 32'h1;
    end
  end

  // a new result beats a read in the same cycle
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rangeValid_reg <= 1'b0;
      rangeAck_reg <= '0;
    end else begin
      rangeValid_reg <= rangeSet || (rangeValid_reg && !rangeClr);
      if (rangeReq) begin
        rangeAck_reg <= rangeAck_reg + 8'h1;
      end
    end
  end

  // ********************************
  // integrated Doppler
  // ********************************
  // a request gives the integration time in clock cycles
  assign dopSet = (dopRemain_reg == 32'h1);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      dopRemain_reg <= '0;
      dopCount_reg <= '0;
      dopData_reg <= '0;
      dopplerForRanging <= '0;
      dopAck_reg <= '0;
    end else if (dopReq) begin
      dopRemain_reg <= wrData;
      dopCount_reg <= '0;
      dopAck_reg <= dopAck_reg + 8'h1;
    end else if (dopRemain_reg != '0) begin
      dopRemain_reg <= dopRemain_reg - 32'h1;
      dopCount_reg <= dopCount_reg + {31'h0, dopplerTick};
      if (dopSet) begin
        // stored for software and handed to the replica side
        dopData_reg <= dopCount_reg + {31'h0, dopplerTick};
        dopplerForRanging <= dopCount_reg + {31'h0, dopplerTick};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      dopValid_reg <= 1'b0;
    end else begin
      dopValid_reg <= (dopSet && !dopReq) || (dopValid_reg && !dopClr);
    end
  end
endmodule
`default_nettype wire

// *** testbench/ranging_code_sequencer_properties.sv ***
// checker: bus handshakes and sequencer outputs of the ranging code sequencer
// assumes it is bound to the sequencer top and sees only its ports
`default_nettype none
module ranging_code_sequencer_checker import ranging_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic [1:0] rresp,
  // sequencer
  input wire logic codeBit,
  input wire logic measurePhase,
  input wire logic [OUT_W-1:0] basebandPhase,
  input wire logic [DATA_W-1:0] dopplerForRanging
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // ********************************
  // assertions
  // ********************************
  AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped early");
  AST_AR_BLOCK: assert property (rvalid |-> !arready)
    else $error("read address taken while answer pending");
  AST_AW_BLOCK: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while response pending");
  AST_R_LAT: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  AST_B_LAT: assert property (awvalid && awready && wvalid && wready |-> ##[1:3] bvalid)
    else $error("write answer late");
  // ticks sit near ten clocks apart, so a code bit never rises within three edges of a change
  AST_TICK_GAP: assert property ($changed(codeBit) |=> (!$rose(codeBit)) [*3])
    else $error("code bit changed off the tone tick");
  AST_RESET: assert property (@(posedge clk) disable iff (1'b0) !nrst |=> !codeBit &&
    !measurePhase && basebandPhase == 16'h0000 && dopplerForRanging == 32'h0 && !bvalid)
    else $error("outputs not cleared by reset");
  cover property ($rose(measurePhase));
  cover property ($changed(codeBit));
  cover property (rvalid && rresp == RESP_SLVERR);
endmodule
bind ranging_code_sequencer ranging_code_sequencer_checker CHK (.clk, .nrst, .awvalid,
  .awready, .wvalid, .wready, .bvalid, .bready, .bresp, .arvalid, .arready, .rvalid,
  .rready, .rdata, .rresp, .codeBit, .measurePhase, .basebandPhase, .dopplerForRanging);
`default_nettype wire

// *** testbench/uplink_modulator_model.sv ***
// partner model: modulator side returning replica epochs and Doppler cycles
// assumes the bench asks for each replica epoch with a one-cycle request
`default_nettype none
module uplink_modulator_model (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // bench request
  input wire logic fireReplica,
  // to the sequencer
  output logic replicaEpoch,
  output logic dopplerTick
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] dopCnt;
  // ********************************
  // doppler cycles and replica epochs
  // ********************************
  // one cycle in three keeps every counting window predictable
  always_ff @(posedge clk) begin
    if (!nrst) begin
      dopCnt <= 2'h0;
    end else begin
      dopCnt <= (dopCnt == 2'h2) ? 2'h0 : dopCnt + 2'h1;
    end
  end
  assign dopplerTick = nrst && dopCnt == 2'h2;
  always_ff @(posedge clk) begin
    replicaEpoch <= nrst && fireReplica;
  end
endmodule
`default_nettype wire

// *** testbench/ranging_code_sequencer_tb_top.sv ***
// bench top: register-level tests of the ranging code sequencer
// assumes the partner model feeds replica epochs and Doppler cycles
`default_nettype none
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin failures++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module ranging_code_sequencer_tb_top import ranging_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, nrst, awvalid, wvalid, bready, arvalid, rready, fire;
  logic awready, wready, bvalid, arready, rvalid, codeBit, measurePhase, coherentRef;
  logic replicaEpoch, dopplerTick;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [DATA_W-1:0] wdata, rdata, dopplerForRanging, d;
  logic [STRB_W-1:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [OUT_W-1:0] basebandPhase, modIndex, p;
  int failures = 0;
  int total_checks = 0;
  int n;
  always #50 clk = ~clk;
  ranging_code_sequencer DUT (.clk, .nrst, .awvalid, .awready, .awaddr, .wvalid, .wready,
    .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready,
    .rdata, .rresp, .replicaEpoch, .dopplerTick, .basebandPhase, .codeBit, .measurePhase,
    .modIndex, .coherentRef, .dopplerForRanging);
  uplink_modulator_model PARTNER (.clk, .nrst, .fireReplica(fire), .replicaEpoch,
    .dopplerTick);
  // ********************************
  // bus tasks
  // ********************************
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v,
      input logic [1:0] e);
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    bready <= 1'b0;
    `CHK("write response", e, bresp)
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic rc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] m,
      input logic [DATA_W-1:0] e);
    rd(a);
    `CHK("register read", e, d & m)
  endtask
  // cycles until the code bit next changes, sampled once per edge
  task automatic gap();
    logic c;
    c = codeBit;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (codeBit === c && n < 100);
  endtask
  task automatic print_verdict();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ********************************
  // tests
  // ********************************
  initial begin
    {clk, nrst, awvalid, wvalid, bready, arvalid, rready, fire} = 8'h00;
    {awaddr, araddr, wdata, wstrb} = '0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    rc(CTRL_ADDR, 32'hFFFF_FFFF, CTRL_RST);
    rc(TONE_ADDR, 32'hFFFF_FFFF, TONE_RST);
    rc(DWELL_ADDR, 32'hFFFF_FFFF, DWELL_RST);
    rc(MODIDX_ADDR, 32'hFFFF_FFFF, 32'h1000_2000);
    rc(STATUS_ADDR, 32'hFFFF_07FF, 32'h0000_0001);
    rd(8'h40);
    `CHK("unmapped read", RESP_SLVERR, r)
    wr(8'h40, 32'h0000_0005, RESP_SLVERR);
    $display("test reset done");
    for (int m = 0; m < 3; m++) begin
      wr(CTRL_ADDR, DATA_W'(m) << CTRL_MODE_LSB, RESP_OKAY);
      `CHK("coherent ref", 1'(m == 1), coherentRef)
    end
    $display("test modes done");
    wr(DWELL_ADDR, 32'h0000_0001, RESP_OKAY);
    wr(CTRL_ADDR, 32'h0000_0021, RESP_OKAY);
    wr(RREQ_ADDR, 32'h0000_0001, RESP_OKAY);
    rc(STATUS_ADDR, 32'h00FF_0000, 32'h0001_0000);
    `CHK("acquire index", MOD_ACQ_RST, modIndex)
    n = 0;
    while (measurePhase !== 1'b1 && n < 500) begin
      @(posedge clk);
      n++;
    end
    `CHK("final reached", 1'b1, measurePhase)
    `CHK("dwell per step", 1'b1, 1'(n >= 15))
    `CHK("measure index", MOD_MEAS_RST, modIndex)
    rc(STATUS_ADDR, 32'h0000_01FF, 32'h0000_0028);
    gap();
    gap();
    `CHK("code 2 half period", 1'b1, 1'(n >= 18 && n <= 22))
    $display("test sequence done");
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (3) @(posedge clk);
    rc(STATUS_ADDR, 32'h0000_0200, 32'h0000_0200);
    rd(RDATA_ADDR);
    `CHK("range interval", 1'b1, 1'(d != 32'h0))
    rc(STATUS_ADDR, 32'h0000_0200, 32'h0000_0000);
    $display("test ranging done");
    wr(DREQ_ADDR, 32'd30, RESP_OKAY);
    repeat (40) @(posedge clk);
    rc(STATUS_ADDR, 32'hFF00_0400, 32'h0100_0400);
    `CHK("doppler to ranging", 32'd10, dopplerForRanging)
    rc(DDATA_ADDR, 32'hFFFF_FFFF, 32'd10);
    $display("test doppler done");
    wr(CTRL_ADDR, 32'h0000_0023, RESP_OKAY);
    repeat (12) @(posedge clk);
    rc(STATUS_ADDR, 32'h0000_000F, 32'h0000_0004);
    wr(CTRL_ADDR, 32'h0000_0020, RESP_OKAY);
    rc(STATUS_ADDR, 32'h0000_01FF, 32'h0000_0001);
    `CHK("measure off", 1'b0, measurePhase)
    p = basebandPhase;
    @(posedge clk);
    `CHK("tone step", 1'b1, 1'(basebandPhase - p - TONE_RST[23:8] <= 16'h1))
    $display("test disable done");
    print_verdict();
  end
  initial begin
    #(20000 * 100);
    failures++;
    print_verdict();
  end
endmodule
`default_nettype wire
